// ---- design/jtp_pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module jtp_pin_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         pin_sync <= '0;
      end else begin
         meta <= pin_in;
         pin_sync <= meta;
      end
   end
endmodule
`default_nettype wire

// ---- design/jtp_tap.sv ----
// Boundary-scan test access port controller sampled on the system clock
`timescale 1ns/10ps
`default_nettype none
module jtp_tap
   import jtp_pkg::*;
#(
   parameter logic [JTP_ID_WIDTH-1:0] ID_VALUE = JTP_ID_DEFAULT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic test_clock_pin,
   input wire logic tms_pin,
   input wire logic tdi_pin,
   input wire logic trst_n_pin,
   output logic tdo_out,
   output logic tdo_oe_n,
   output logic [JTP_IR_WIDTH-1:0] instruction,
   output logic tap_in_reset
);
   logic [2:0] pins_s;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic tck_d;
   logic tck_rise;
   logic tck_fall;
   logic tap_rst_n;
   jtp_state_type state;
   jtp_state_type next_state;
   logic [JTP_IR_WIDTH-1:0] ir_shift;
   logic [JTP_ID_WIDTH-1:0] id_shift;
   logic bypass_bit;
   logic in_shift_ir;
   logic in_shift_dr;
   logic dr_serial;
   logic next_tdo;

   function automatic jtp_state_type tap_step(input jtp_state_type s, input logic m);
      case (s)
         ST_RESET: tap_step = m ? ST_RESET : ST_IDLE;
         ST_IDLE: tap_step = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: tap_step = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: tap_step = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: tap_step = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: tap_step = m ? ST_UP_DR : ST_PA_DR;
         ST_PA_DR: tap_step = m ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: tap_step = m ? ST_UP_DR : ST_SH_DR;
         ST_UP_DR: tap_step = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: tap_step = m ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: tap_step = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: tap_step = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: tap_step = m ? ST_UP_IR : ST_PA_IR;
         ST_PA_IR: tap_step = m ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: tap_step = m ? ST_UP_IR : ST_SH_IR;
         ST_UP_IR: tap_step = m ? ST_SEL_DR : ST_IDLE;
         default: tap_step = ST_RESET;
      endcase
   endfunction

   // Test clock is slow against clk, so it is sampled like any pin
   jtp_pin_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .pin_in({test_clock_pin, tms_pin, tdi_pin}),
      .pin_sync(pins_s)
   );

   assign tck_s = pins_s[2];
   assign tms_s = pins_s[1];
   assign tdi_s = pins_s[0];
   assign tck_rise = tck_s & ~tck_d;
   assign tck_fall = ~tck_s & tck_d;
   // test reset pin
   // Pin feeds the async reset directly; release is not synchronised to clk
   assign tap_rst_n = rstn & trst_n_pin;
   assign next_state = tap_step(state, tms_s);
   assign in_shift_ir = (state == ST_SH_IR);
   assign in_shift_dr = (state == ST_SH_DR);
   assign dr_serial = (instruction == JTP_OP_IDCODE) ? id_shift[0] : bypass_bit;
   assign next_tdo = in_shift_ir ? ir_shift[0] : dr_serial;
   assign tap_in_reset = (state == ST_RESET);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= tck_s;
      end
   end

   // TMS-high reset path
   // Held-high mode-select lands in ST_RESET by the fifth rise through the graph
   always_ff @(posedge clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         state <= ST_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         instruction <= JTP_OP_IDCODE;
      end else if (tck_rise && state == ST_RESET) begin
         instruction <= JTP_OP_IDCODE;
      end else if (tck_rise && state == ST_UP_IR) begin
         instruction <= ir_shift;
      end
   end

   always_ff @(posedge clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         ir_shift <= JTP_IR_CAPTURE;
      end else if (tck_rise && state == ST_CAP_IR) begin
         ir_shift <= JTP_IR_CAPTURE;
      end else if (tck_rise && in_shift_ir) begin
         ir_shift <= {tdi_s, ir_shift[JTP_IR_WIDTH-1:1]};
      end
   end

   always_ff @(posedge clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         id_shift <= ID_VALUE;
         bypass_bit <= 1'b0;
      end else if (tck_rise && state == ST_CAP_DR) begin
         id_shift <= ID_VALUE;
         bypass_bit <= 1'b0;
      end else if (tck_rise && in_shift_dr) begin
         id_shift <= {tdi_s, id_shift[JTP_ID_WIDTH-1:1]};
         bypass_bit <= tdi_s;
      end
   end

   // output enable on falls
   // Enable and data both move on the fall, so the pin never glitches mid-bit
   always_ff @(posedge clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tdo_out <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tdo_out <= next_tdo;
         tdo_oe_n <= ~(in_shift_ir | in_shift_dr);
      end
   end

   // Checking helpers: consecutive high mode-select samples
   logic [2:0] tms_high_count;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tms_high_count <= 3'h0;
      end else if (tck_rise && !tms_s) begin
         tms_high_count <= 3'h0;
      end else if (tck_rise && tms_high_count != JTP_TMS_COUNT_MAX) begin
         tms_high_count <= tms_high_count + 3'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!tap_rst_n);

   a_tms_five_reset: assert property (
      (tms_high_count == JTP_TMS_COUNT_MAX) |-> (state == ST_RESET))
      else $error("Controller not in reset after five high mode-select samples");

   a_trst_forces_reset: assert property (
      @(posedge clk) disable iff (!rstn) (!trst_n_pin) |-> (state == ST_RESET))
      else $error("Controller not in reset while test reset pin is low");

   a_tdo_idle_released: assert property (
      (state == ST_RESET || state == ST_IDLE) |-> tdo_oe_n)
      else $error("Data output driven outside a shift state");

   a_tdo_drive_shift: assert property (
      (tck_fall && (in_shift_ir || in_shift_dr)) |=> !tdo_oe_n)
      else $error("Data output not driven during shift");

   a_bypass_takes_tdi: assert property (
      (tck_rise && in_shift_dr) |=> (bypass_bit == $past(tdi_s)))
      else $error("Bypass bit did not capture the data input");

   a_idle_from_reset: assert property (
      (tck_rise && state == ST_RESET && !tms_s) |=> (state == ST_IDLE))
      else $error("Reset with mode-select low did not go to idle");

   a_tdo_on_fall: assert property (
      (tck_fall && in_shift_ir) |=> (tdo_out == $past(ir_shift[0])))
      else $error("Instruction bit not presented on the fall");

   a_state_holds: assert property (
      (!tck_rise) |=> $stable(state))
      else $error("State moved without a test-clock rise");

   a_ir_capture_value: assert property (
      (tck_rise && state == ST_CAP_IR) |=> (ir_shift == JTP_IR_CAPTURE))
      else $error("Instruction shift did not load the capture value");

   a_ir_update_loads: assert property (
      (tck_rise && state == ST_UP_IR) |=> (instruction == $past(ir_shift)))
      else $error("Instruction not loaded on leaving update");

   a_tdo_release_exit: assert property (
      (tck_fall && !in_shift_ir && !in_shift_dr) |=> tdo_oe_n)
      else $error("Data output still driven outside a shift state");

   a_idcode_in_reset: assert property (
      (tck_rise && state == ST_RESET) |=> (instruction == JTP_OP_IDCODE))
      else $error("Instruction not returned to identify while in reset");

   c_update_ir: cover property (tck_rise && state == ST_UP_IR);
   c_shift_dr: cover property (tck_fall && in_shift_dr ##1 !tdo_oe_n);
   c_tms_reset: cover property (tms_high_count == JTP_TMS_COUNT_MAX);
   c_bypass_sel: cover property (instruction == JTP_OP_BYPASS && in_shift_dr);
endmodule
`default_nettype wire

// ---- inc/jtp_pkg.sv ----
// Constants and types shared by the test access port design
package jtp_pkg;
   localparam int JTP_IR_WIDTH = 4;
   localparam int JTP_ID_WIDTH = 32;
   localparam int JTP_SYNC_STAGES = 2;
   localparam int JTP_TMS_RESET_COUNT = 5;
   localparam logic [2:0] JTP_TMS_COUNT_MAX = 3'h5;
   localparam logic [JTP_IR_WIDTH-1:0] JTP_IR_CAPTURE = 4'h1;
   localparam logic [JTP_IR_WIDTH-1:0] JTP_OP_IDCODE = 4'h2;
   localparam logic [JTP_IR_WIDTH-1:0] JTP_OP_BYPASS = 4'hf;
   // Arbitrary identification value, bit 0 set as the scan convention wants
   localparam logic [JTP_ID_WIDTH-1:0] JTP_ID_DEFAULT = 32'h0a5c_0001;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
      ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
   } jtp_state_type;
endpackage

// ---- test/jtag_test_access_port_tb.sv ----
// Self-checking bench for the test access port
`timescale 1ns/10ps
`default_nettype none
module jtag_test_access_port_tb;
   import jtp_pkg::*;
   logic clk;
   logic rstn;
   wire tck, tms, tdi, trst_n, s_valid, s_bit, tdo_out, tdo_oe_n, tap_in_reset;
   wire [JTP_IR_WIDTH-1:0] instruction;
   logic exp_q[$];
   int num_errors = 0;
   int compares = 0;
   logic [31:0] lfsr = 32'hc521;
   logic [3:0] op;
   logic s_valid_d = 1'b0;
   jtp_tap uut (.clk(clk), .rstn(rstn), .test_clock_pin(tck), .tms_pin(tms),
      .tdi_pin(tdi), .trst_n_pin(trst_n), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
      .instruction(instruction), .tap_in_reset(tap_in_reset));
   jtp_tester tester (.clk(clk), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
      .test_clock_pin(tck), .tms_pin(tms), .tdi_pin(tdi), .trst_n_pin(trst_n),
      .sample_valid(s_valid), .sample_bit(s_bit));
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk_bit(input logic got, input logic e);
      compares++;
      if (got !== e) begin
         num_errors++;
         $display("[ERR] %0t data out %b expected %b", $time, got, e);
      end
   endtask
   task automatic chk_state(input logic r, input logic [JTP_IR_WIDTH-1:0] ir);
      compares++;
      if (tap_in_reset !== r || instruction !== ir) begin
         num_errors++;
         $display("[ERR] %0t state %b ir %h", $time, tap_in_reset, instruction);
      end
   endtask
   task automatic test_done;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic step(input logic m, input logic d, input logic e, input logic c);
      if (c) exp_q.push_back(e);
      tester.cycle(m, d, c);
   endtask
   task automatic walk(input logic [7:0] p, input int n);
      for (int i = 0; i < n; i++) step(p[i], 1'b1, 1'b0, 1'b0);
   endtask
   task automatic shift_dr(input logic [3:0] o);
      logic prev;
      logic e;
      prev = 1'b0;
      walk(8'h01, 3);
      for (int i = 0; i < 8; i++) begin
         lfsr = next_rand(lfsr);
         e = (o == JTP_OP_IDCODE) ? JTP_ID_DEFAULT[i] : prev;
         step(i == 7, lfsr[0], e, 1'b1);
         prev = lfsr[0];
      end
      step(1'b1, 1'b0, 1'bz, 1'b1);
      step(1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic load_ir(input logic [3:0] o);
      walk(8'h03, 4);
      for (int i = 0; i < 4; i++) step(i == 3, o[i], JTP_IR_CAPTURE[i], 1'b1);
      step(1'b1, 1'b0, 1'bz, 1'b1);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      chk_state(1'b0, o);
   endtask
   // Sample read one edge after the tester posts it, so bit and strobe have settled
   always @(posedge clk) begin
      s_valid_d <= s_valid;
      if (s_valid && !s_valid_d) begin
         if (exp_q.size() == 0) begin
            compares++;
            num_errors++;
            $display("[ERR] %0t data out sample with no expectation", $time);
         end else begin
            chk_bit(s_bit, exp_q.pop_front());
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done;
   end
   initial begin
      rstn = 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      chk_state(1'b1, JTP_OP_IDCODE);
      chk_bit(tdo_oe_n, 1'b1);
      walk(8'h00, 1);
      shift_dr(JTP_OP_IDCODE);
      for (int k = 0; k < 3; k++) begin
         lfsr = next_rand(lfsr);
         op = (k == 0) ? JTP_OP_IDCODE : (k == 1) ? lfsr[3:0] : JTP_OP_BYPASS;
         load_ir(op);
         shift_dr(op);
      end
      // Into shift, then four highs: only reaches select-IR, no reset yet
      walk(8'h79, 7);
      repeat (3) @(posedge clk);
      chk_state(1'b0, JTP_OP_BYPASS);
      // Fifth high enters reset, sixth reloads the identify instruction
      walk(8'h03, 2);
      repeat (3) @(posedge clk);
      chk_state(1'b1, JTP_OP_IDCODE);
      walk(8'h00, 1);
      load_ir(JTP_OP_BYPASS);
      walk(8'h01, 3);
      step(1'b0, 1'b1, 1'b0, 1'b1);
      tester.trst_pulse;
      @(posedge clk);
      chk_state(1'b1, JTP_OP_IDCODE);
      chk_bit(tdo_oe_n, 1'b1);
      repeat (4) @(posedge clk);
      test_done;
   end
endmodule
`default_nettype wire

// ---- test/jtp_tester.sv ----
// Behavioural scan tester driving the test pins
`timescale 1ns/10ps
`default_nettype none
module jtp_tester (
   input wire logic clk,
   input wire logic tdo_out,
   input wire logic tdo_oe_n,
   output logic test_clock_pin,
   output logic tms_pin,
   output logic tdi_pin,
   output logic trst_n_pin,
   output logic sample_valid,
   output logic sample_bit
);
   // Released data out floats, so a stale bit cannot pass
   wire tdo_line = tdo_oe_n ? 1'bz : tdo_out;
   initial begin
      test_clock_pin = 1'b0;
      tms_pin = 1'b1;
      tdi_pin = 1'b1;
      trst_n_pin = 1'b1;
      sample_valid = 1'b0;
      sample_bit = 1'b0;
   end
   // Mode and data set in low phase
   task automatic cycle(input logic m, input logic d, input logic c);
      @(posedge clk);
      test_clock_pin <= 1'b0;
      tms_pin <= m;
      tdi_pin <= d;
      sample_valid <= 1'b0;
      repeat (4) @(posedge clk);
      test_clock_pin <= 1'b1;
      repeat (3) @(posedge clk);
      sample_bit <= tdo_line;
      sample_valid <= c;
   endtask
   task automatic trst_pulse;
      @(posedge clk);
      trst_n_pin <= 1'b0;
      repeat (2) @(posedge clk);
      trst_n_pin <= 1'b1;
   endtask
endmodule
`default_nettype wire
